// File: testbench/dcp_asserts.sv
// Checker for pin control, mode decode and period match of the dual-compare PWM timer
`timescale 1ns/1ns
module dcp_asserts (
  input wire logic core_clk, // Clock
  input wire logic reset_n, // Reset, active low
  input wire logic [dcp_pkg::DCP_AW-1:0] reg_addr, // Register address
  input wire logic [dcp_pkg::DCP_DW-1:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic cutoff_req, // Cutoff request
  input wire logic [7:0] gpio_out, // Port values
  input wire logic [7:0] gpio_oe, // Port enables
  input wire logic pin_a0_out, // Pin A0 level
  input wire logic pin_a0_oe, // Pin A0 enable
  input wire logic pin_b0_out, // Pin B0 level
  input wire logic pin_b0_oe, // Pin B0 enable
  input wire logic pwm_active, // PWM in effect
  input wire logic period_match // Period match
);
  import dcp_pkg::*;
  // ==========================================================
  // Shadow of the registers, kept from observed writes
  typedef struct packed {
    logic [7:0] func;
    logic [7:0] cut;
    logic [7:0] dis;
    logic [7:0] lvl;
    logic run0;
  } dcp_shadow_type;
  dcp_shadow_type sh_reg, sh_next;
  always_comb begin
    sh_next = sh_reg;
    if (reg_wr) begin
      case (reg_addr)
        DCP_OFF_FUNC: sh_next.func = reg_wdata[7:0];
        DCP_OFF_CUTOFF: sh_next.cut = reg_wdata[7:0];
        DCP_OFF_OUTDIS: sh_next.dis = reg_wdata[7:0];
        DCP_OFF_LEVEL: sh_next.lvl = reg_wdata[7:0];
        DCP_OFF_RUN: sh_next.run0 = reg_wdata[DCP_RUN0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) sh_reg <= {DCP_RST_FUNC, DCP_RST_CUTOFF, DCP_RST_OUTDIS, DCP_RST_LEVEL, 1'b0};
    else sh_reg <= sh_next;
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_dis_follow;
    $past(reset_n) && $past(sh_reg.dis[0]) |-> pin_a0_out == $past(gpio_out[0]) && pin_a0_oe == $past(gpio_oe[0]);
  endproperty
  a_dis_follow: assert property (p_dis_follow) else $error("disabled A0 not following port");
  property p_stop_a0;
    (!sh_reg.run0 && !sh_reg.dis[0] && sh_reg.cut[7:6] == DCP_CUT_NONE && !cutoff_req && $stable(sh_reg.lvl))[*4]
      |-> pin_a0_out == sh_reg.lvl[0] && pin_a0_oe;
  endproperty
  a_stop_a0: assert property (p_stop_a0) else $error("stopped A0 not at initial level");
  property p_stop_b0;
    (!sh_reg.run0 && !sh_reg.dis[1] && sh_reg.cut[5:4] == DCP_CUT_NONE && !cutoff_req && $stable(sh_reg.lvl))[*4]
      |-> pin_b0_out == sh_reg.lvl[1] && pin_b0_oe;
  endproperty
  a_stop_b0: assert property (p_stop_b0) else $error("stopped B0 not at initial level");
  property p_cut_a0;
    cutoff_req && !sh_reg.dis[0] && sh_reg.cut[7:6] != DCP_CUT_NONE
      |=> pin_a0_oe == ($past(sh_reg.cut[7:6]) != DCP_CUT_HIZ) && (!pin_a0_oe || pin_a0_out == $past(sh_reg.cut[6]));
  endproperty
  a_cut_a0: assert property (p_cut_a0) else $error("A0 cutoff level wrong");
  property p_cut_b0;
    cutoff_req && !sh_reg.dis[1] && sh_reg.cut[5:4] != DCP_CUT_NONE
      |=> pin_b0_oe == ($past(sh_reg.cut[5:4]) != DCP_CUT_HIZ) && (!pin_b0_oe || pin_b0_out == $past(sh_reg.cut[4]));
  endproperty
  a_cut_b0: assert property (p_cut_b0) else $error("B0 cutoff level wrong");
  property p_pwm_mode;
    $past(reset_n) |-> pwm_active == ($past(sh_reg.func[1:0]) == DCP_CMB_TIMER && !$past(sh_reg.func[7]));
  endproperty
  a_pwm_mode: assert property (p_pwm_mode) else $error("mode decode wrong");
  property p_match_level;
    period_match && !sh_reg.dis[0] && !cutoff_req && $stable(sh_reg.lvl) |=> pin_a0_out == $past(sh_reg.lvl[0]);
  endproperty
  a_match_level: assert property (p_match_level) else $error("A0 not reset by period match");
  property p_match_run;
    period_match |-> $past(sh_reg.run0);
  endproperty
  a_match_run: assert property (p_match_run) else $error("match while counter0 stopped");
  c_match: cover property (period_match && pwm_active);
  c_cut: cover property (cutoff_req && !pin_a0_oe);
  c_high: cover property (pwm_active && pin_a0_out && pin_b0_out);
endmodule
bind dcp_top dcp_asserts u_dcp_asserts (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .cutoff_req, .gpio_out,
  .gpio_oe, .pin_a0_out, .pin_a0_oe, .pin_b0_out, .pin_b0_oe, .pwm_active, .period_match);

// File: testbench/dcp_load.sv
// Model of the external load that sees the eight timer pins
`timescale 1ns/1ns
module dcp_load (
  input wire logic core_clk, // Clock
  input wire logic [7:0] pin_out, // Pin levels, order a0,b0,c0,d0,a1,b1,c1,d1
  input wire logic [7:0] pin_oe, // Pin drive enables
  output logic [7:0] pad // Level seen by the load
);
  logic [7:0] float_reg = 8'h00;
  // ==========================================================
  // No pull on the pads: a released pad wanders every cycle so a stale level never passes
  always_ff @(posedge core_clk) float_reg <= ~pad;
  always_comb pad = (pin_oe & pin_out) | (~pin_oe & float_reg);
endmodule

// File: testbench/tb_dcp_top.sv
// Self-checking testbench for the dual-compare PWM timer
`timescale 1ns/1ns
module tb_dcp_top;
  import dcp_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [DCP_AW-1:0] reg_addr = 8'h00;
  logic [DCP_DW-1:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic cutoff_req = 1'b0;
  logic [7:0] gpio_out = 8'hA5;
  logic [7:0] gpio_oe = 8'h3C;
  logic [DCP_DW-1:0] reg_rdata;
  logic [7:0] pin_out, pin_oe, pad;
  logic pwm_active, period_match;
  logic [15:0] rv, rv2;
  logic [15:0] gv [8] = '{16'h0004, 16'h0003, 16'h0002, 16'h0001, 16'h0009, 16'h0009, 16'h0009, 16'h0009};
  logic [7:0] funcs [5] = '{8'h00, 8'h80, 8'h01, 8'h81, 8'h03};
  logic [7:0] cmb [3] = '{8'h00, 8'h03, 8'h02};
  int fails = 0;
  int n_compared = 0;
  int hi_a, hi_b, n_match;
  always #25 core_clk = ~core_clk;
  dcp_top dut (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cutoff_req(cutoff_req), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .pin_a0_out(pin_out[0]), .pin_a0_oe(pin_oe[0]), .pin_b0_out(pin_out[1]), .pin_b0_oe(pin_oe[1]),
    .pin_c0_out(pin_out[2]), .pin_c0_oe(pin_oe[2]), .pin_d0_out(pin_out[3]), .pin_d0_oe(pin_oe[3]),
    .pin_a1_out(pin_out[4]), .pin_a1_oe(pin_oe[4]), .pin_b1_out(pin_out[5]), .pin_b1_oe(pin_oe[5]),
    .pin_c1_out(pin_out[6]), .pin_c1_oe(pin_oe[6]), .pin_d1_out(pin_out[7]), .pin_d1_oe(pin_oe[7]),
    .pwm_active(pwm_active), .period_match(period_match));
  dcp_load load (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe), .pad(pad));
  // ==========================================================
  // Bus and compare tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    rd(a, rv);
    chk(rv, e);
  endtask
  // Runs counter0 and counts high cycles on the pads over four periods of five cycles
  task automatic measure(input logic [15:0] lvl);
    wr(DCP_OFF_LEVEL, lvl);
    wr(DCP_OFF_RUN, 16'h0001);
    repeat (10) @(posedge core_clk);
    hi_a = 0;
    hi_b = 0;
    n_match = 0;
    repeat (20) begin
      @(posedge core_clk);
      #1;
      hi_a += pad[0];
      hi_b += pad[1];
      n_match += period_match;
    end
    wr(DCP_OFF_RUN, 16'h0000);
  endtask
  task automatic finish_test();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========================================================
  // Tests
  initial begin
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1 chk({pin_out, pin_oe}, {gpio_out, gpio_oe});
    rc(DCP_OFF_MODE, {8'h00, DCP_RST_MODE});
    rc(DCP_OFF_FUNC, {8'h00, DCP_RST_FUNC});
    rc(DCP_OFF_OUTDIS, {8'h00, DCP_RST_OUTDIS});
    rc(8'h0A, 16'h0000);
    wr(DCP_OFF_MODE, 16'hFFFF);
    rc(DCP_OFF_MODE, 16'h00F1);
    wr(DCP_OFF_MODE, 16'h0000);
    wr(DCP_OFF_FUNC, 16'h0000);
    wr(DCP_OFF_CLR, {13'h0000, DCP_CLR_PERIOD});
    wr(DCP_OFF_CUTOFF, 16'h0000);
    wr(DCP_OFF_OUTDIS, 16'h00FC);
    for (int k = 0; k < 8; k++) wr(8'(DCP_OFF_GR_BASE + k), gv[k]);
    chk({15'h0000, pin_out[2]}, {15'h0000, gpio_out[2]});
    for (int l = 0; l < 2; l++) begin
      measure(l ? 16'h0003 : 16'h0000);
      chk(16'(hi_a), l ? 16'h000C : 16'h0008);
      chk(16'(hi_b), l ? 16'h000C : 16'h0008);
      chk(16'(n_match), 16'h0004);
      repeat (4) @(posedge core_clk);
      #1 chk({14'h0000, pad[1:0]}, l ? 16'h0003 : 16'h0000);
      rd(DCP_OFF_CNT0, rv2);
      repeat (3) @(posedge core_clk);
      rc(DCP_OFF_CNT0, rv2);
    end
    rc(DCP_OFF_GR_BASE, 16'h0004);
    foreach (cmb[i]) begin
      for (int k = 0; k < 8; k++) wr(8'(DCP_OFF_GR_BASE + k), k < 4 ? gv[k] : 16'(k + 16 * i));
      wr(DCP_OFF_MODE, 16'h00F0);
      wr(DCP_OFF_FUNC, {8'h00, cmb[i]});
      // Underflow mode runs counter1 alone, so a period match cannot stand in for the transfer
      wr(DCP_OFF_RUN, i == 2 ? 16'h0002 : 16'h0001);
      repeat (12) @(posedge core_clk);
      wr(DCP_OFF_RUN, 16'h0000);
      for (int k = 0; k < 4; k++) begin
        rc(8'(DCP_OFF_GR_BASE + k), 16'(k + 4 + 16 * i));
      end
    end
    foreach (funcs[i]) begin
      wr(DCP_OFF_FUNC, {8'h00, funcs[i]});
      repeat (2) @(posedge core_clk);
      #1 chk({15'h0000, pwm_active}, {15'h0000, funcs[i] == 8'h00});
    end
    wr(DCP_OFF_MODE, 16'h0001);
    wr(DCP_OFF_RUN, 16'h0001);
    repeat (5) @(posedge core_clk);
    wr(DCP_OFF_RUN, 16'h0000);
    rd(DCP_OFF_CNT0, rv2);
    rc(DCP_OFF_CNT1, rv2);
    wr(DCP_OFF_MODE, 16'h0000);
    wr(DCP_OFF_FUNC, 16'h0000);
    wr(DCP_OFF_LEVEL, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      wr(DCP_OFF_CUTOFF, 16'(c * 16'h0050));
      cutoff_req <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1 chk({14'h0000, pin_oe[1:0]}, {14'h0000, {2{c != 1}}});
      if (c != 1) chk({14'h0000, pin_out[1:0]}, {14'h0000, {2{c == 3}}});
      @(posedge core_clk);
      cutoff_req <= 1'b0;
    end
    finish_test();
  end
  // Whole sequence needs well under 2000 cycles; allow a wide margin
  initial begin
    repeat (5000) @(posedge core_clk);
    fails++;
    finish_test();
  end
endmodule

// File: verilog/dcp_pkg.sv
// Package for the dual-compare PWM timer: register map, field positions, reset values
package dcp_pkg;

  // ==========================================================
  // Widths
  localparam int DCP_AW = 8;
  localparam int DCP_DW = 16;

  // ==========================================================
  // Register offsets (word addresses on the register port)
  localparam logic [7:0] DCP_OFF_MODE = 8'h00;
  localparam logic [7:0] DCP_OFF_FUNC = 8'h01;
  localparam logic [7:0] DCP_OFF_CUTOFF = 8'h02;
  localparam logic [7:0] DCP_OFF_OUTDIS = 8'h03;
  localparam logic [7:0] DCP_OFF_LEVEL = 8'h04;
  localparam logic [7:0] DCP_OFF_RUN = 8'h05;
  localparam logic [7:0] DCP_OFF_CLR = 8'h06;
  localparam logic [7:0] DCP_OFF_STATUS = 8'h07;
  localparam logic [7:0] DCP_OFF_CNT0 = 8'h08;
  localparam logic [7:0] DCP_OFF_CNT1 = 8'h09;
  // General registers occupy 0x10..0x17 in the order of the index constants below
  localparam logic [7:0] DCP_OFF_GR_BASE = 8'h10;
  localparam logic [4:0] DCP_GR_PAGE = 5'h02;

  // ==========================================================
  // General register indices
  localparam int DCP_GR_PERIOD = 0;
  localparam int DCP_GR_B0_RESET = 1;
  localparam int DCP_GR_A1_SET = 2;
  localparam int DCP_GR_B1_SET = 3;
  localparam int DCP_GR_BUF_OFS = 4;
  localparam int DCP_GR_NUM = 8;

  // ==========================================================
  // Field positions
  localparam int DCP_MODE_LOCKSTEP = 0;
  localparam int DCP_MODE_BUF_BASE = 4;
  localparam int DCP_FUNC_DCPWM = 7;
  localparam int DCP_FUNC_CMB_HI = 1;
  localparam int DCP_FUNC_CMB_LO = 0;
  localparam int DCP_CUT_A0_HI = 7;
  localparam int DCP_CUT_A0_LO = 6;
  localparam int DCP_CUT_B0_HI = 5;
  localparam int DCP_CUT_B0_LO = 4;
  localparam int DCP_RUN0 = 0;
  localparam int DCP_RUN1 = 1;

  // ==========================================================
  // Encodings
  localparam logic [1:0] DCP_CMB_TIMER = 2'h0;
  localparam logic [1:0] DCP_CMB_RSYNC = 2'h1;
  localparam logic [2:0] DCP_CLR_PERIOD = 3'h1;
  localparam logic [1:0] DCP_CUT_NONE = 2'h0;
  localparam logic [1:0] DCP_CUT_HIZ = 2'h1;
  localparam logic [1:0] DCP_CUT_LOW = 2'h2;
  localparam logic [1:0] DCP_CUT_HIGH = 2'h3;

  // ==========================================================
  // Reset values
  localparam logic [7:0] DCP_RST_MODE = 8'h00;
  localparam logic [7:0] DCP_RST_FUNC = 8'h80;
  localparam logic [7:0] DCP_RST_CUTOFF = 8'h00;
  localparam logic [7:0] DCP_RST_OUTDIS = 8'hFF;
  localparam logic [7:0] DCP_RST_LEVEL = 8'h00;
  localparam logic [7:0] DCP_RST_RUN = 8'h00;
  localparam logic [2:0] DCP_RST_CLR = 3'h0;
  localparam logic [15:0] DCP_RST_GR = 16'hFFFF;
  localparam logic [15:0] DCP_RST_CNT = 16'h0000;
  localparam logic [15:0] DCP_CNT_ONE = 16'h0001;

endpackage

// File: verilog/dcp_top.sv
// Dual-compare PWM timer: configuration registers, two counters, buffered compares, pin control
`timescale 1ns/1ns
module dcp_top (
  input wire logic core_clk, // Peripheral clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic [dcp_pkg::DCP_AW-1:0] reg_addr, // Register word address
  input wire logic [dcp_pkg::DCP_DW-1:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [dcp_pkg::DCP_DW-1:0] reg_rdata, // Read data, cycle after strobe
  input wire logic cutoff_req, // Forced cutoff request, active high level
  input wire logic [7:0] gpio_out, // General port output values per pin
  input wire logic [7:0] gpio_oe, // General port output enables per pin
  output logic pin_a0_out, // Pin A0 level
  output logic pin_a0_oe, // Pin A0 drive enable
  output logic pin_b0_out, // Pin B0 level
  output logic pin_b0_oe, // Pin B0 drive enable
  output logic pin_c0_out, // Pin C0 level
  output logic pin_c0_oe, // Pin C0 drive enable
  output logic pin_d0_out, // Pin D0 level
  output logic pin_d0_oe, // Pin D0 drive enable
  output logic pin_a1_out, // Pin A1 level
  output logic pin_a1_oe, // Pin A1 drive enable
  output logic pin_b1_out, // Pin B1 level
  output logic pin_b1_oe, // Pin B1 drive enable
  output logic pin_c1_out, // Pin C1 level
  output logic pin_c1_oe, // Pin C1 drive enable
  output logic pin_d1_out, // Pin D1 level
  output logic pin_d1_oe, // Pin D1 drive enable
  output logic pwm_active, // Dual-compare PWM waveform in effect
  output logic period_match // Counter0 met period register in the previous cycle
);
  import dcp_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic [7:0] timer_mode_cfg;
    logic [7:0] function_ctl;
    logic [7:0] cutoff_filter_cfg;
    logic [7:0] output_master_disable;
    logic [7:0] output_level_ctl;
    logic [7:0] run_ctl;
    logic [2:0] clear_src_sel;
    logic [15:0] counter0;
    logic [15:0] counter1;
    logic [DCP_GR_NUM-1:0][15:0] gr;
    logic a0_lvl;
    logic b0_lvl;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic pwm_act;
    logic per_match;
    logic [15:0] rdata;
  } dcp_state_type;

  dcp_state_type state_reg;
  dcp_state_type state_next;

  // ==========================================================
  // Decoded controls
  logic [1:0] comb_sel;
  logic comp_mode;
  logic dual_pwm;
  logic run0;
  logic run1;
  logic lockstep;
  logic match_per;
  logic match_b0;
  logic match_a1;
  logic match_b1;
  logic underflow1;
  logic xfer;
  logic [15:0] cnt0_adv;
  logic [15:0] cnt1_adv;
  logic [7:0] tmr_val;
  logic [1:0] cut_a0;
  logic [1:0] cut_b0;
  logic gr_hit;
  logic [2:0] gr_idx;

  always_comb begin
    comb_sel = {state_reg.function_ctl[DCP_FUNC_CMB_HI], state_reg.function_ctl[DCP_FUNC_CMB_LO]};
    // Upper combination bit set means complementary mode
    comp_mode = comb_sel[1];
    // PWM select only counts in plain combination setting
    dual_pwm = (comb_sel == DCP_CMB_TIMER) && !state_reg.function_ctl[DCP_FUNC_DCPWM];
    run0 = state_reg.run_ctl[DCP_RUN0];
    run1 = state_reg.run_ctl[DCP_RUN1];
    lockstep = state_reg.timer_mode_cfg[DCP_MODE_LOCKSTEP];
    match_per = run0 && (state_reg.counter0 == state_reg.gr[DCP_GR_PERIOD]);
    match_b0 = run0 && (state_reg.counter0 == state_reg.gr[DCP_GR_B0_RESET]);
    match_a1 = run0 && (state_reg.counter0 == state_reg.gr[DCP_GR_A1_SET]);
    match_b1 = run0 && (state_reg.counter0 == state_reg.gr[DCP_GR_B1_SET]);
    underflow1 = comp_mode && run1 && (state_reg.counter1 == DCP_RST_CNT);
    // Buffer transfer moment depends on the combination mode
    if (comp_mode) begin
      xfer = comb_sel[0] ? match_per : underflow1;
    end else begin
      xfer = match_per;
    end
    cut_a0 = {state_reg.cutoff_filter_cfg[DCP_CUT_A0_HI], state_reg.cutoff_filter_cfg[DCP_CUT_A0_LO]};
    cut_b0 = {state_reg.cutoff_filter_cfg[DCP_CUT_B0_HI], state_reg.cutoff_filter_cfg[DCP_CUT_B0_LO]};
    gr_hit = (reg_addr[7:3] == DCP_GR_PAGE);
    gr_idx = reg_addr[2:0];
  end

  // ==========================================================
  // Counter advance
  always_comb begin
    cnt0_adv = state_reg.counter0;
    if (run0) begin
      if (match_per && (state_reg.clear_src_sel == DCP_CLR_PERIOD)) begin
        cnt0_adv = DCP_RST_CNT;
      end else begin
        cnt0_adv = state_reg.counter0 + DCP_CNT_ONE;
      end
    end
    cnt1_adv = state_reg.counter1;
    if (lockstep) begin
      // Synchronous operation: counter1 tracks counter0 exactly
      cnt1_adv = cnt0_adv;
    end else if (run1) begin
      // Independent operation; down-counting only in complementary mode
      if (comp_mode) begin
        cnt1_adv = state_reg.counter1 - DCP_CNT_ONE;
      end else begin
        cnt1_adv = state_reg.counter1 + DCP_CNT_ONE;
      end
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    state_next = state_reg;
    state_next.counter0 = cnt0_adv;
    state_next.counter1 = cnt1_adv;
    state_next.per_match = match_per;
    state_next.pwm_act = dual_pwm;

    // Buffer transfers; a deselected buffer is an ordinary register
    for (int i = 0; i < DCP_GR_BUF_OFS; i++) begin
      if (xfer && state_reg.timer_mode_cfg[DCP_MODE_BUF_BASE + i]) begin
        state_next.gr[i] = state_reg.gr[i + DCP_GR_BUF_OFS];
      end
    end

    // A0 waveform: reset match wins over set match when both coincide
    if (!run0) begin
      state_next.a0_lvl = state_reg.output_level_ctl[0];
    end else if (dual_pwm && match_per) begin
      state_next.a0_lvl = state_reg.output_level_ctl[0];
    end else if (dual_pwm && match_a1) begin
      state_next.a0_lvl = !state_reg.output_level_ctl[0];
    end

    // B0 waveform: same priority as A0
    if (!run0) begin
      state_next.b0_lvl = state_reg.output_level_ctl[1];
    end else if (dual_pwm && match_b0) begin
      state_next.b0_lvl = state_reg.output_level_ctl[1];
    end else if (dual_pwm && match_b1) begin
      state_next.b0_lvl = !state_reg.output_level_ctl[1];
    end

    // Timer-owned pin values; pins without a waveform hold their initial level
    tmr_val = state_reg.output_level_ctl;
    tmr_val[0] = state_reg.a0_lvl;
    tmr_val[1] = state_reg.b0_lvl;

    for (int p = 0; p < 8; p++) begin
      if (state_reg.output_master_disable[p]) begin
        state_next.pin_out[p] = gpio_out[p];
        state_next.pin_oe[p] = gpio_oe[p];
      end else begin
        state_next.pin_out[p] = tmr_val[p];
        state_next.pin_oe[p] = 1'b1;
      end
    end

    // Forced cutoff overrides timer drive on A0 and B0 only
    if (cutoff_req && !state_reg.output_master_disable[0]) begin
      case (cut_a0)
        DCP_CUT_HIZ: begin
          state_next.pin_oe[0] = 1'b0;
        end
        DCP_CUT_LOW: begin
          state_next.pin_out[0] = 1'b0;
        end
        DCP_CUT_HIGH: begin
          state_next.pin_out[0] = 1'b1;
        end
        default: begin
        end
      endcase
    end
    if (cutoff_req && !state_reg.output_master_disable[1]) begin
      case (cut_b0)
        DCP_CUT_HIZ: begin
          state_next.pin_oe[1] = 1'b0;
        end
        DCP_CUT_LOW: begin
          state_next.pin_out[1] = 1'b0;
        end
        DCP_CUT_HIGH: begin
          state_next.pin_out[1] = 1'b1;
        end
        default: begin
        end
      endcase
    end

    // Register writes; software writes win over counting and transfers
    if (reg_wr) begin
      if (gr_hit) begin
        state_next.gr[gr_idx] = reg_wdata;
      end else begin
        case (reg_addr)
          DCP_OFF_MODE: begin
            state_next.timer_mode_cfg = reg_wdata[7:0] & 8'hF1;
          end
          DCP_OFF_FUNC: begin
            state_next.function_ctl = reg_wdata[7:0] & 8'hCF;
          end
          DCP_OFF_CUTOFF: begin
            state_next.cutoff_filter_cfg = reg_wdata[7:0];
          end
          DCP_OFF_OUTDIS: begin
            state_next.output_master_disable = reg_wdata[7:0];
          end
          DCP_OFF_LEVEL: begin
            state_next.output_level_ctl = reg_wdata[7:0];
          end
          DCP_OFF_RUN: begin
            state_next.run_ctl = reg_wdata[7:0] & 8'h03;
          end
          DCP_OFF_CLR: begin
            state_next.clear_src_sel = reg_wdata[2:0];
          end
          DCP_OFF_CNT0: begin
            state_next.counter0 = reg_wdata;
          end
          DCP_OFF_CNT1: begin
            state_next.counter1 = reg_wdata;
          end
          default: begin
          end
        endcase
      end
    end

    // Register reads; unmapped addresses return zero
    state_next.rdata = 16'h0000;
    if (reg_rd) begin
      if (gr_hit) begin
        state_next.rdata = state_reg.gr[gr_idx];
      end else begin
        case (reg_addr)
          DCP_OFF_MODE: begin
            state_next.rdata = {8'h00, state_reg.timer_mode_cfg};
          end
          DCP_OFF_FUNC: begin
            state_next.rdata = {8'h00, state_reg.function_ctl};
          end
          DCP_OFF_CUTOFF: begin
            state_next.rdata = {8'h00, state_reg.cutoff_filter_cfg};
          end
          DCP_OFF_OUTDIS: begin
            state_next.rdata = {8'h00, state_reg.output_master_disable};
          end
          DCP_OFF_LEVEL: begin
            state_next.rdata = {8'h00, state_reg.output_level_ctl};
          end
          DCP_OFF_RUN: begin
            state_next.rdata = {8'h00, state_reg.run_ctl};
          end
          DCP_OFF_CLR: begin
            state_next.rdata = {13'h0000, state_reg.clear_src_sel};
          end
          DCP_OFF_STATUS: begin
            state_next.rdata = {12'h000, underflow1, dual_pwm, state_reg.b0_lvl, state_reg.a0_lvl};
          end
          DCP_OFF_CNT0: begin
            state_next.rdata = state_reg.counter0;
          end
          DCP_OFF_CNT1: begin
            state_next.rdata = state_reg.counter1;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg.timer_mode_cfg <= DCP_RST_MODE;
      state_reg.function_ctl <= DCP_RST_FUNC;
      state_reg.cutoff_filter_cfg <= DCP_RST_CUTOFF;
      state_reg.output_master_disable <= DCP_RST_OUTDIS;
      state_reg.output_level_ctl <= DCP_RST_LEVEL;
      state_reg.run_ctl <= DCP_RST_RUN;
      state_reg.clear_src_sel <= DCP_RST_CLR;
      state_reg.counter0 <= DCP_RST_CNT;
      state_reg.counter1 <= DCP_RST_CNT;
      state_reg.gr <= {DCP_GR_NUM{DCP_RST_GR}};
      state_reg.a0_lvl <= 1'b0;
      state_reg.b0_lvl <= 1'b0;
      state_reg.pin_out <= 8'h00;
      state_reg.pin_oe <= 8'h00;
      state_reg.pwm_act <= 1'b0;
      state_reg.per_match <= 1'b0;
      state_reg.rdata <= 16'h0000;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata = state_reg.rdata;
  assign pin_a0_out = state_reg.pin_out[0];
  assign pin_a0_oe = state_reg.pin_oe[0];
  assign pin_b0_out = state_reg.pin_out[1];
  assign pin_b0_oe = state_reg.pin_oe[1];
  assign pin_c0_out = state_reg.pin_out[2];
  assign pin_c0_oe = state_reg.pin_oe[2];
  assign pin_d0_out = state_reg.pin_out[3];
  assign pin_d0_oe = state_reg.pin_oe[3];
  assign pin_a1_out = state_reg.pin_out[4];
  assign pin_a1_oe = state_reg.pin_oe[4];
  assign pin_b1_out = state_reg.pin_out[5];
  assign pin_b1_oe = state_reg.pin_oe[5];
  assign pin_c1_out = state_reg.pin_out[6];
  assign pin_c1_oe = state_reg.pin_oe[6];
  assign pin_d1_out = state_reg.pin_out[7];
  assign pin_d1_oe = state_reg.pin_oe[7];
  assign pwm_active = state_reg.pwm_act;
  assign period_match = state_reg.per_match;

endmodule
